/* hdl/cpm_cfg.svh */
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH
// Overview of operation
// [R1] Thirteen-bit prescaler advances once per system clock.
// [R2] Reset clears prescaler; counting starts on release.
// [R3] Standby and subsleep stop and clear prescaler.
// [R4] Prescaler value is never visible to software.
// [R5] Prescaler taps give system clock /2 to /8192.
// [R6] Each peripheral picks its own tap independently.
// [R7] Active/sleep system clock is divided oscillator clock.
// [R8] Divide field 0XX,/8,/16,/32,/64; applied at SLEEP.
// [R9] Active mode clocks CPU and all peripherals.
// [R10] Sleep mode halts CPU, peripherals keep running.
// [R11] Standby halts CPU and all peripherals.
// [R12] Subsleep halts everything and holds port outputs.
// [R13] Each peripheral can be halted on its own.
// [R14] Standby select: SLEEP enters sleep or standby.
// [R15] Wait field sets standby wake-up stabilisation time.
// [R16] Software picks wait of 6.5 ms or more.
// [R17] Low four control bits read zero, ignore writes.
// [R18] Standby wake restarts clock, counts wait, releases.
// [R19] Interrupt in sleep returns to active mode.

// Register offsets on the software port.
`define CPM_ADDR_W       4
`define CPM_OFF_PMC      4'h0
`define CPM_OFF_PMC2     4'h1
`define CPM_OFF_HALT1    4'h2
`define CPM_OFF_HALT2    4'h3
`define CPM_OFF_TSEL0    4'h4
`define CPM_OFF_STAT     4'h8

// Field positions.
`define CPM_PMC_STANDBY_SELECT_BIT 7
`define CPM_PMC_WAIT_MSB 6
`define CPM_PMC_WAIT_LSB 4
`define CPM_PMC2_DIV_MSB 4
`define CPM_PMC2_DIV_LSB 2

// Reset values.
`define CPM_PMC_RST      8'h00
`define CPM_PMC2_RST     8'h00
`define CPM_HALT_RST     8'h00
`define CPM_TSEL_RST     4'h0
`define CPM_DIV_RST      3'h0
`define CPM_PRE_RST      13'h0000

// Prescaler and divider widths and terminal counts.
`define CPM_PRE_W        13
`define CPM_DIV_W        6
`define CPM_DIV8_LAST    6'h07
`define CPM_DIV16_LAST   6'h0f
`define CPM_DIV32_LAST   6'h1f
`define CPM_DIV64_LAST   6'h3f

// Standby wake-up wait, in system clock states.
`define CPM_WAIT_W       18
`define CPM_WAIT_0       18'h02000
`define CPM_WAIT_1       18'h04000
`define CPM_WAIT_2       18'h08000
`define CPM_WAIT_3       18'h10000
`define CPM_WAIT_4       18'h20000
`define CPM_WAIT_5       18'h00400
`define CPM_WAIT_6       18'h00080
`define CPM_WAIT_7       18'h00010

`endif

/* hdl/cpm_pkg.sv */
package cpm_pkg;

   typedef enum logic [2:0] {
      CPM_ACTIVE   = 3'b000,
      CPM_SLEEP    = 3'b001,
      CPM_STANDBY  = 3'b010,
      CPM_SUBSLEEP = 3'b011,
      CPM_WAKE     = 3'b100
   } cpm_mode_e;

   typedef logic [7:0] cpm_byte_t;

endpackage

/* hdl/cpm_tick_if.sv */
`timescale 1ns/1ps
interface cpm_tick_if #(parameter int PW = 13);
   logic          phi_en;
   logic          clr;
   logic [PW:1]   taps;

   modport drv (output phi_en, output clr, input taps);
   modport pre (input phi_en, input clr, output taps);
endinterface

/* hdl/cpm_prescaler.sv */
`timescale 1ns/1ps
`include "cpm_cfg.svh"
module cpm_prescaler
   import cpm_pkg::*;
(
   input wire logic  sys_clk,
   input wire logic  rst_n,
   cpm_tick_if.pre   tk
);

   logic [`CPM_PRE_W-1:0] cnt_q;

   // The count stays internal; only tap strobes leave this module.
   always_ff @(posedge sys_clk) begin // see [R4]
      if (!rst_n || tk.clr) begin // see [R2] see [R3]
         cnt_q <= `CPM_PRE_RST;
      end else if (tk.phi_en) begin
         cnt_q <= cnt_q + 1'b1; // see [R1]
      end
   end

   // Tap k strobes once every 2**k system clock states.
   for (genvar k = 1; k <= `CPM_PRE_W; k++) begin : g_tap
      assign tk.taps[k] = tk.phi_en && (&cnt_q[k-1:0]); // see [R5]
   end

   property p_pre_inc;
      @(posedge sys_clk) disable iff (!rst_n)
      (tk.phi_en && !tk.clr) |=> (cnt_q == $past(cnt_q) + 1'b1);
   endproperty
   a_pre_inc: assert property (p_pre_inc) else $error("prescaler did not advance"); // see [R1]

   property p_pre_clr;
      @(posedge sys_clk) disable iff (!rst_n)
      tk.clr |=> (cnt_q == `CPM_PRE_RST);
   endproperty
   a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared"); // see [R3]

endmodule

/* hdl/cpm_wait_timer.sv */
`timescale 1ns/1ps
module cpm_wait_timer #(
   parameter int W = 18
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic          start,
   input  wire logic [W-1:0]  load,
   input  wire logic          tick,
   output logic               busy,
   output logic               done
);

   logic [W-1:0] rem_q;

   // Counts exactly load ticks after start, then pulses done.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rem_q <= '0;
      end else if (start) begin
         rem_q <= load;
      end else if (busy && tick) begin
         rem_q <= rem_q - 1'b1;
      end
   end

   assign busy = (rem_q != '0);
   assign done = busy && tick && (rem_q == W'(1));

endmodule

/* hdl/cpm_top.sv */
`timescale 1ns/1ps
`include "cpm_cfg.svh"
module cpm_top
   import cpm_pkg::*;
#(
   parameter int                N_PERIPH = 4,
   parameter logic [`CPM_WAIT_W-1:0] ST_WAIT_0 = `CPM_WAIT_0,
   parameter logic [`CPM_WAIT_W-1:0] ST_WAIT_1 = `CPM_WAIT_1,
   parameter logic [`CPM_WAIT_W-1:0] ST_WAIT_2 = `CPM_WAIT_2,
   parameter logic [`CPM_WAIT_W-1:0] ST_WAIT_3 = `CPM_WAIT_3,
   parameter logic [`CPM_WAIT_W-1:0] ST_WAIT_4 = `CPM_WAIT_4
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic [`CPM_ADDR_W-1:0]  reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_we,
   input  wire logic                    reg_re,
   output logic [7:0]                   reg_rdata_q,
   input  wire logic                    sleep_req,
   input  wire logic                    subsleep_req,
   input  wire logic                    irq_wake,
   output logic                         phi_en_q,
   output logic                         cpu_halt_q,
   output logic [15:0]                  periph_halt_q,
   output logic [N_PERIPH-1:0]          periph_tick_q,
   output logic                         port_hold_q,
   output logic [2:0]                   mode_out_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   cpm_byte_t                  pmc_q;
   cpm_byte_t                  pmc2_q;
   logic [15:0]                halt_q;
   logic [3:0]                 tsel_q [N_PERIPH];
   logic [2:0]                 div_act_q;
   cpm_mode_e                  mode_q;
   logic [`CPM_DIV_W-1:0]      div_cnt_q;
   logic [`CPM_DIV_W-1:0]      div_last;
   logic                       clk_run;
   logic                       mode_halt;
   logic                       wt_start;
   logic                       wt_done;
   logic                       wt_busy;
   logic [`CPM_WAIT_W-1:0]     wt_load;
   logic [15:0]                tap_vec;
   logic [2:0]                 wait_sel;

   cpm_tick_if #(.PW(`CPM_PRE_W)) tk ();

   assign wait_sel = pmc_q[`CPM_PMC_WAIT_MSB:`CPM_PMC_WAIT_LSB];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pmc_q  <= `CPM_PMC_RST;
         pmc2_q <= `CPM_PMC2_RST;
         halt_q <= {`CPM_HALT_RST, `CPM_HALT_RST};
      end else if (reg_we) begin
         case (reg_addr)
            `CPM_OFF_PMC: begin
               pmc_q <= {reg_wdata[7:4], 4'h0}; // see [R17]
            end
            `CPM_OFF_PMC2: begin
               pmc2_q <= {3'h0, reg_wdata[`CPM_PMC2_DIV_MSB:`CPM_PMC2_DIV_LSB], 2'h0};
            end
            `CPM_OFF_HALT1: begin
               halt_q[7:0] <= reg_wdata; // see [R13]
            end
            `CPM_OFF_HALT2: begin
               halt_q[15:8] <= reg_wdata; // see [R13]
            end
            default: begin
            end
         endcase
      end
   end

   // Each peripheral owns a tap selector: 0 off, 1..13 picks /2 to /8192.
   for (genvar i = 0; i < N_PERIPH; i++) begin : g_tsel
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            tsel_q[i] <= `CPM_TSEL_RST;
         end else if (reg_we && reg_addr == `CPM_OFF_TSEL0 + `CPM_ADDR_W'(i)) begin
            tsel_q[i] <= reg_wdata[3:0]; // see [R6]
         end
      end
   end

   // Reads answer in the next cycle; unmapped offsets read zero.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_re) begin
         reg_rdata_q <= 8'h00;
         case (reg_addr)
            `CPM_OFF_PMC:   reg_rdata_q <= {pmc_q[7:4], 4'h0}; // see [R17]
            `CPM_OFF_PMC2:  reg_rdata_q <= pmc2_q;
            `CPM_OFF_HALT1: reg_rdata_q <= halt_q[7:0];
            `CPM_OFF_HALT2: reg_rdata_q <= halt_q[15:8];
            `CPM_OFF_STAT:  reg_rdata_q <= {1'b0, mode_q, 1'b0, div_act_q};
            default: begin
               for (int j = 0; j < N_PERIPH; j++) begin
                  if (reg_addr == `CPM_OFF_TSEL0 + `CPM_ADDR_W'(j)) begin
                     reg_rdata_q <= {4'h0, tsel_q[j]};
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power mode sequencing.

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_q <= CPM_ACTIVE;
      end else begin
         case (mode_q)
            CPM_ACTIVE: begin
               if (subsleep_req) begin
                  mode_q <= CPM_SUBSLEEP;
               end else if (sleep_req) begin // see [R14]
                  mode_q <= pmc_q[`CPM_PMC_STANDBY_SELECT_BIT] ? CPM_STANDBY : CPM_SLEEP;
               end
            end
            CPM_SLEEP: begin
               if (irq_wake) begin
                  mode_q <= CPM_ACTIVE; // see [R19]
               end
            end
            CPM_STANDBY, CPM_SUBSLEEP: begin
               if (irq_wake) begin
                  mode_q <= CPM_WAKE; // see [R18]
               end
            end
            CPM_WAKE: begin
               if (wt_done) begin
                  mode_q <= CPM_ACTIVE; // see [R18]
               end
            end
            default: begin
               mode_q <= CPM_ACTIVE;
            end
         endcase
      end
   end

   // A new divide setting is only adopted when SLEEP executes.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         div_act_q <= `CPM_DIV_RST;
      end else if (mode_q == CPM_ACTIVE && sleep_req) begin
         div_act_q <= pmc2_q[`CPM_PMC2_DIV_MSB:`CPM_PMC2_DIV_LSB]; // see [R8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // System clock enable from the oscillator divider.

   assign clk_run = (mode_q != CPM_STANDBY) && (mode_q != CPM_SUBSLEEP); // see [R3]

   always_comb begin
      case (div_act_q)
         3'b100:  div_last = `CPM_DIV8_LAST;
         3'b101:  div_last = `CPM_DIV16_LAST;
         3'b110:  div_last = `CPM_DIV32_LAST;
         3'b111:  div_last = `CPM_DIV64_LAST;
         default: div_last = '0; // see [R8]
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !clk_run || div_cnt_q >= div_last) begin
         div_cnt_q <= '0;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         phi_en_q <= 1'b0;
      end else begin
         phi_en_q <= clk_run && (div_cnt_q >= div_last); // see [R7]
      end
   end

   assign tk.phi_en = phi_en_q && clk_run; // see [R3]
   assign tk.clr    = !clk_run; // see [R3]

   cpm_prescaler u_pre (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tk      (tk)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Standby wake-up wait.

   assign wt_start = irq_wake && !clk_run;

   always_comb begin
      case (wait_sel) // see [R15]
         3'h0:    wt_load = ST_WAIT_0;
         3'h1:    wt_load = ST_WAIT_1;
         3'h2:    wt_load = ST_WAIT_2;
         3'h3:    wt_load = ST_WAIT_3;
         3'h4:    wt_load = ST_WAIT_4;
         3'h5:    wt_load = `CPM_WAIT_5;
         3'h6:    wt_load = `CPM_WAIT_6;
         default: wt_load = `CPM_WAIT_7;
      endcase
   end

   cpm_wait_timer #(.W(`CPM_WAIT_W)) u_wait (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .start   (wt_start),
      .load    (wt_load),
      .tick    (phi_en_q),
      .busy    (wt_busy),
      .done    (wt_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Halt, hold and peripheral tick outputs.

   assign mode_halt = !clk_run || (mode_q == CPM_WAKE); // see [R11] see [R12]
   assign tap_vec   = {2'h0, tk.taps, 1'b0};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cpu_halt_q    <= 1'b0;
         periph_halt_q <= 16'h0000;
         port_hold_q   <= 1'b0;
         mode_out_q    <= CPM_ACTIVE;
      end else begin
         cpu_halt_q    <= (mode_q != CPM_ACTIVE); // see [R9] see [R10]
         periph_halt_q <= halt_q | {16{mode_halt}}; // see [R13]
         port_hold_q   <= (mode_q == CPM_SUBSLEEP); // see [R12]
         mode_out_q    <= mode_q;
      end
   end

   for (genvar i = 0; i < N_PERIPH; i++) begin : g_tick
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            periph_tick_q[i] <= 1'b0;
         end else begin
            periph_tick_q[i] <= !halt_q[i] && tap_vec[tsel_q[i]]; // see [R5] see [R6]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_stop_clear;
      !clk_run |-> (tk.taps == '0) ##1 !phi_en_q;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("clock ran while stopped"); // see [R3]

   property p_active_run;
      (mode_q == CPM_ACTIVE && halt_q == 16'h0000) |=> (!cpu_halt_q && periph_halt_q == 16'h0000);
   endproperty
   a_active_run: assert property (p_active_run) else $error("active mode halted a unit"); // see [R9]

   property p_sleep_cpu;
      (mode_q == CPM_SLEEP) |=> (cpu_halt_q && periph_halt_q == $past(halt_q));
   endproperty
   a_sleep_cpu: assert property (p_sleep_cpu) else $error("sleep mode halts wrong"); // see [R10]

   property p_standby_halt;
      (mode_q == CPM_STANDBY) |=> (cpu_halt_q && (&periph_halt_q) && !port_hold_q);
   endproperty
   a_standby_halt: assert property (p_standby_halt) else $error("standby did not halt"); // see [R11]

   property p_subsleep_hold;
      (mode_q == CPM_SUBSLEEP) |=> (port_hold_q && cpu_halt_q && (&periph_halt_q));
   endproperty
   a_subsleep_hold: assert property (p_subsleep_hold) else $error("subsleep not held"); // see [R12]

   property p_sleep_select;
      (mode_q == CPM_ACTIVE && sleep_req && !subsleep_req)
         |=> (mode_q == (pmc_q[`CPM_PMC_STANDBY_SELECT_BIT] ? CPM_STANDBY : CPM_SLEEP));
   endproperty
   a_sleep_select: assert property (p_sleep_select) else $error("wrong sleep target"); // see [R14]

   property p_sleep_wake;
      (mode_q == CPM_SLEEP && irq_wake) |=> (mode_q == CPM_ACTIVE) ##1 !cpu_halt_q;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake failed"); // see [R19]

   property p_wait_16;
      (mode_q == CPM_STANDBY && irq_wake && wait_sel == 3'h7 && !div_act_q[2])
         |-> ##17 (mode_q == CPM_WAKE) ##1 (mode_q == CPM_ACTIVE);
   endproperty
   a_wait_16: assert property (p_wait_16) else $error("wake wait length wrong"); // see [R15] see [R18]

   property p_div_hold;
      !(mode_q == CPM_ACTIVE && sleep_req) |=> $stable(div_act_q);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider changed early"); // see [R8]

   property p_pmc_low;
      (reg_re && reg_addr == `CPM_OFF_PMC) |=> (reg_rdata_q[3:0] == 4'h0);
   endproperty
   a_pmc_low: assert property (p_pmc_low) else $error("reserved bits not zero"); // see [R17]

   property p_tick_tap;
      (tsel_q[0] == 4'h1 && tk.taps[1] && !halt_q[0]) |=> periph_tick_q[0];
   endproperty
   a_tick_tap: assert property (p_tick_tap) else $error("tap tick missing"); // see [R6]

   c_sleep:    cover property (mode_q == CPM_ACTIVE ##1 mode_q == CPM_SLEEP);
   c_standby:  cover property (mode_q == CPM_ACTIVE ##1 mode_q == CPM_STANDBY);
   c_wake:     cover property (mode_q == CPM_WAKE ##1 mode_q == CPM_ACTIVE);
   c_subsleep: cover property (mode_q == CPM_SUBSLEEP ##1 mode_q == CPM_WAKE);

endmodule

/* bench/cpm_periph_model.sv */
`timescale 1ns/1ps
// Stand-ins for the CPU core and the peripherals: each counts the enables it is handed.
module cpm_periph_model #(
   parameter int N = 4
) (
   input  wire logic          sys_clk,
   input  wire logic          clr,
   input  wire logic          phi_en_q,
   input  wire logic          cpu_halt_q,
   input  wire logic [N-1:0]  periph_tick_q,
   output logic [31:0]        cpu_cnt,
   output logic [31:0]        phi_cnt,
   output logic [31:0]        tick_cnt [N]
);
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         cpu_cnt <= '0;
         phi_cnt <= '0;
      end else begin
         phi_cnt <= phi_cnt + 32'(phi_en_q);
         cpu_cnt <= cpu_cnt + 32'(phi_en_q & ~cpu_halt_q);
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < N; i++) begin
         tick_cnt[i] <= clr ? 32'h0 : tick_cnt[i] + 32'(periph_tick_q[i]);
      end
   end
endmodule

/* bench/test_clock_prescaler_power_modes.sv */
`timescale 1ns/1ps
`include "cpm_cfg.svh"
module test_clock_prescaler_power_modes
   import cpm_pkg::*;
;
   `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
      $display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end

   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_we = 1'b0;
   logic        reg_re = 1'b0;
   logic [7:0]  reg_rdata_q;
   logic [2:0]  req_q = 3'h0;
   logic        phi_en_q;
   logic        cpu_halt_q;
   logic [15:0] periph_halt_q;
   logic [3:0]  periph_tick_q;
   logic        port_hold_q;
   logic [2:0]  mode_out_q;
   logic        clr = 1'b1;
   logic [31:0] cpu_cnt;
   logic [31:0] phi_cnt;
   logic [31:0] tick_cnt [4];
   int          err_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   cpm_top #(.N_PERIPH(4), .ST_WAIT_0(18'h00020)) dut (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_we        (reg_we),
      .reg_re        (reg_re),
      .reg_rdata_q   (reg_rdata_q),
      .sleep_req     (req_q[0]),
      .subsleep_req  (req_q[1]),
      .irq_wake      (req_q[2]),
      .phi_en_q      (phi_en_q),
      .cpu_halt_q    (cpu_halt_q),
      .periph_halt_q (periph_halt_q),
      .periph_tick_q (periph_tick_q),
      .port_hold_q   (port_hold_q),
      .mode_out_q    (mode_out_q)
   );

   cpm_periph_model #(.N(4)) far (
      .sys_clk       (sys_clk),
      .clr           (clr),
      .phi_en_q      (phi_en_q),
      .cpu_halt_q    (cpu_halt_q),
      .periph_tick_q (periph_tick_q),
      .cpu_cnt       (cpu_cnt),
      .phi_cnt       (phi_cnt),
      .tick_cnt      (tick_cnt)
   );

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("errors %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_we <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_re <= 1'b0;
      #1;
      `CHK(reg_rdata_q, e)
   endtask

   // Pulses one request line for a cycle; returns just after the taking edge.
   task automatic req(input int k);
      @(posedge sys_clk);
      req_q[k] <= 1'b1;
      @(posedge sys_clk);
      req_q[k] <= 1'b0;
   endtask

   task automatic settle2;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   // Clears the far-side counters, then lets n edges be counted.
   task automatic count(input int n);
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wake_edges(output int n);
      n = 0;
      #1;
      while (mode_out_q !== 3'h0 && n < 1000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_chk(`CPM_OFF_PMC, 8'h00);
      rd_chk(`CPM_OFF_STAT, 8'h00);
      count(16);
      `CHK(phi_cnt, 32'd16)
      `CHK(cpu_cnt, 32'd16)
   endtask

   task automatic t_regs;
      wr(`CPM_OFF_PMC, 8'hff);
      rd_chk(`CPM_OFF_PMC, 8'hf0);
      wr(`CPM_OFF_PMC2, 8'hff);
      rd_chk(`CPM_OFF_PMC2, 8'h1c);
      rd_chk(4'hf, 8'h00);
      wr(`CPM_OFF_PMC, 8'h00);
      wr(`CPM_OFF_PMC2, 8'h00);
   endtask

   task automatic t_taps;
      wr(4'h4, 8'h01);
      wr(4'h5, 8'h03);
      wr(4'h6, 8'h0d);
      wr(4'h7, 8'h0e);
      count(16384);
      `CHK(tick_cnt[0], 32'd8192)
      `CHK(tick_cnt[1], 32'd2048)
      `CHK(tick_cnt[2], 32'd2)
      `CHK(tick_cnt[3], 32'd0)
      wr(`CPM_OFF_HALT1, 8'h02);
      count(64);
      `CHK(periph_halt_q, 16'h0002)
      `CHK(tick_cnt[1], 32'd0)
      `CHK(tick_cnt[0], 32'd32)
      wr(`CPM_OFF_HALT1, 8'h00);
   endtask

   task automatic t_div;
      logic [2:0] c;
      for (int i = 0; i < 5; i++) begin
         c = (i == 4) ? 3'h3 : 3'(i + 4);
         wr(`CPM_OFF_PMC2, {3'h0, c, 2'h0});
         req(0);
         settle2;
         `CHK(mode_out_q, 3'h1)
         `CHK(cpu_halt_q, 1'b1)
         `CHK(periph_halt_q, 16'h0000)
         count(16);
         `CHK(cpu_cnt, 32'd0)
         rd_chk(`CPM_OFF_STAT, {4'h1, 1'b0, c});
         req(2);
         settle2;
         `CHK(mode_out_q, 3'h0)
         `CHK(cpu_halt_q, 1'b0)
         count(256);
         `CHK(phi_cnt, c[2] ? 32'd256 >> (c - 3'h1) : 32'd256)
      end
   endtask

   task automatic t_standby;
      int n;
      logic [2:0] w;
      for (int i = 0; i < 2; i++) begin
         w = (i == 0) ? 3'h7 : 3'h0;
         wr(`CPM_OFF_PMC, {1'b1, w, 4'h0});
         req(0);
         settle2;
         `CHK(mode_out_q, 3'h2)
         `CHK(periph_halt_q, 16'hffff)
         `CHK(cpu_halt_q, 1'b1)
         count(32);
         `CHK(phi_cnt, 32'd0)
         `CHK(tick_cnt[0], 32'd0)
         req(2);
         wake_edges(n);
         `CHK(n, (w == 3'h7) ? 18 : 34)
         `CHK(periph_halt_q, 16'h0000)
      end
      wr(`CPM_OFF_PMC, 8'h00);
   endtask

   task automatic t_subsleep;
      int n;
      req(1);
      settle2;
      `CHK(mode_out_q, 3'h3)
      `CHK(port_hold_q, 1'b1)
      `CHK(periph_halt_q, 16'hffff)
      req(2);
      wake_edges(n);
      `CHK(n, 34)
      `CHK(port_hold_q, 1'b0)
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      clr <= 1'b0;
      t_reset();
      t_regs();
      t_taps();
      t_div();
      t_standby();
      t_subsleep();
      end_sim();
   end
endmodule
